// ==== include/pll_cfg_pkg.sv ====
// Shared constants for the synthesizer configuration loader.
// Assumes one 100 MHz clock; all pins arrive synchronous to it.
package pll_cfg_pkg;
    // Clock rate, kept for time conversions
    localparam int CLK_PERIOD_NS = 10;
    // Field widths of the divider configuration
    localparam int M_W     = 9;
    localparam int N_W     = 2;
    localparam int T_W     = 3;
    localparam int SHIFT_W = 14;
    // Reference pre-divide and its counter
    localparam int REF_DIV = 8;
    localparam logic [2:0] REF_LAST = 3'h7;
    localparam logic [2:0] REF_HALF = 3'h3;
    // Field positions inside the serial shift register, first bit at the top
    localparam int SH_T_LSB = 11;
    localparam int SH_N_LSB = 9;
    localparam int SH_M_LSB = 0;
    // Test-select codes
    localparam logic [2:0] TEST_SHIFT  = 3'h0;
    localparam logic [2:0] TEST_HIGH   = 3'h1;
    localparam logic [2:0] TEST_FREF   = 3'h2;
    localparam logic [2:0] TEST_MCNT   = 3'h3;
    localparam logic [2:0] TEST_SYNTH_CLOCK_OUT   = 3'h4;
    localparam logic [2:0] TEST_LOW    = 3'h5;
    localparam logic [2:0] TEST_BYPASS = 3'h6;
    localparam logic [2:0] TEST_FOUT4  = 3'h7;
    // Register map, byte addresses
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_CONFIG = 8'h04;
    localparam logic [7:0] ADDR_SHIFT  = 8'h08;
    localparam logic [7:0] ADDR_PUMP   = 8'h0C;
    // Control register: bit 0 gates the output enable pin
    localparam int CTRL_OE_BIT = 0;
    localparam logic CTRL_OE_RESET = 1'b1;
    // Config readback layout
    localparam int CFG_N_LSB = 9;
    localparam int CFG_T_LSB = 11;
    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Last count of a half period of the output divider (2^code ticks): ratio 2^(code+1)
    function automatic logic [2:0] half_last(input logic [1:0] code);
        logic [3:0] half;
        half = 4'h1 << code;
        return 3'(half - 4'h1);
    endfunction
endpackage

// ==== hdl/out_divider.sv ====
// Output divider with glitch-free synchronous enable.
// Assumes i_tick is a one-cycle event from the selected oscillator.
`timescale 1ns/1ps
`default_nettype none
module out_divider
    import pll_cfg_pkg::*;
(
    input  wire logic           i_clock,   // System clock
    input  wire logic           i_srst,    // Sync reset, active high
    input  wire logic           i_tick,    // Oscillator event
    input  wire logic [N_W-1:0] i_ratio,   // Divide code
    input  wire logic           i_enable,  // Requested enable
    output logic                o_clock,   // Gated divided clock
    output logic                o_level    // Ungated divided clock
);
    logic [2:0] cnt_r;
    logic       div_r;
    logic       en_r;

    // Toggle every 2^code ticks, so both halves are equal
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            cnt_r <= 3'h0;
            div_r <= 1'b0;
        end else if (i_tick) begin
            if (cnt_r >= half_last(i_ratio)) begin
                cnt_r <= 3'h0;
                div_r <= ~div_r;
            end else begin
                cnt_r <= cnt_r + 3'h1;
            end
        end
    end

    // Enable changes only while the divider is low: no runt pulse
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            en_r <= 1'b0;
        end else if (!div_r) begin
            en_r <= i_enable;
        end
    end

    assign o_clock = div_r & en_r;
    assign o_level = div_r;

    oe_sync_a: assert property (@(posedge i_clock) disable iff (i_srst)
        $changed(en_r) |-> !$past(div_r))
        else $error("enable changed while output high");
    ratio_a: assert property (@(posedge i_clock) disable iff (i_srst)
        (i_tick && i_ratio == 2'h0 && $stable(i_ratio)) |=> div_r != $past(div_r))
        else $error("divide by two did not toggle");
endmodule // out_divider
`default_nettype wire

// ==== hdl/pll_divider_config_loader.sv ====
// Configuration loader and dividers of a frequency synthesizer.
// Assumes oscillator events and serial pins sampled on i_clock.
// Functional notes
// - Reference oscillator divided by eight
// - Loop divider output drives phase comparison
// - Output divide code 00/01/10/11 gives 2/4/8/16
// - Divided output keeps fifty percent duty
// - Loop divider is nine bits, bit 8 MSB
// - Parallel strobe rising edge captures pins
// - Parallel strobe low makes latches transparent
// - Parallel loading wins over serial loading
// - Fourteen-bit shift register, shifts on serial clock
// - Serial strobe falling edge captures shift register
// - Serial strobe high passes shift contents through
// - Test pin node chosen by serial select
// - Output enable synchronous, no runt pulses
// - Stream order: test, output, loop, MSB first
// - Parallel strobe low forces test select 000
// - Code 110 bypasses with serial clock
//
// Register access over AXI4-Lite and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module pll_divider_config_loader
    import pll_cfg_pkg::*;
(
    input  wire logic           i_clock,        // System clock, 100 MHz
    input  wire logic           i_srst,         // Sync reset, active high
    input  wire logic           i_xtal_tick,    // Reference oscillator event
    input  wire logic           i_vco_tick,     // Oscillator event
    input  wire logic [M_W-1:0] i_par_m,        // Parallel loop divider
    input  wire logic [N_W-1:0] i_par_n,        // Parallel output code
    input  wire logic           i_par_load_n,   // Parallel strobe, low transparent
    input  wire logic           i_ser_clock,    // Serial clock level
    input  wire logic           i_ser_data,     // Serial data
    input  wire logic           i_ser_load,     // Serial strobe, high transparent
    input  wire logic           i_out_en,       // Output enable, active high
    output logic                o_synth_clock_out, // Synthesized clock
    output logic                o_test_out,     // Test pin
    output logic                o_pump_up,      // Speed oscillator up
    output logic                o_pump_down,    // Slow oscillator down
    input  wire logic [7:0]     i_awaddr,       // AXI write address
    input  wire logic           i_awvalid,      // AXI
    output logic                o_awready,      // AXI
    input  wire logic [31:0]    i_wdata,        // AXI write data
    input  wire logic [3:0]     i_wstrb,        // AXI byte enables
    input  wire logic           i_wvalid,       // AXI
    output logic                o_wready,       // AXI
    output logic [1:0]          o_bresp,        // AXI
    output logic                o_bvalid,       // AXI
    input  wire logic           i_bready,       // AXI
    input  wire logic [7:0]     i_araddr,       // AXI read address
    input  wire logic           i_arvalid,      // AXI
    output logic                o_arready,      // AXI
    output logic [31:0]         o_rdata,        // AXI read data
    output logic [1:0]          o_rresp,        // AXI
    output logic                o_rvalid,       // AXI
    input  wire logic           i_rready        // AXI
);
    typedef enum logic [0:0] {WR_COLLECT, WR_RESP} wr_state_type;

    wr_state_type     wr_state_r;
    logic             aw_have_r;
    logic             w_have_r;
    logic [7:0]       waddr_r;
    logic [31:0]      wdata_r;
    logic             wstrb0_r;
    logic             ctrl_oe_r;
    logic [SHIFT_W-1:0] shift_r;
    logic             ser_clk_d_r;
    logic             ser_load_d_r;
    logic [M_W-1:0]   cfg_m_r;
    logic [N_W-1:0]   cfg_n_r;
    logic [T_W-1:0]   cfg_t_r;
    logic [2:0]       ref_cnt_r;
    logic             fref_r;
    logic [M_W-1:0]   loop_cnt_r;
    logic             mcnt_out_r;
    logic [1:0]       f4_cnt_r;
    logic             synth_clock_out_prev_r;
    logic             test_r;
    logic             up_r;
    logic             down_r;
    logic             ser_rise;
    logic             ser_load_fall;
    logic             bypass;
    logic             div_tick;
    logic             fref_evt;
    logic             fb_evt;
    logic             synth_clock_out_gated;
    logic             synth_clock_out_level;
    logic             synth_clock_out_rise;

    // Serial pin edges; the pins are already synchronous
    assign ser_rise      = i_ser_clock & ~ser_clk_d_r;
    assign ser_load_fall = ~i_ser_load & ser_load_d_r;
    assign bypass        = (cfg_t_r == TEST_BYPASS);

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            ser_clk_d_r  <= 1'b0;
            ser_load_d_r <= 1'b0;
        end else begin
            ser_clk_d_r  <= i_ser_clock;
            ser_load_d_r <= i_ser_load;
        end
    end

    // Shift register: first bit shifted ends at the top
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            shift_r <= '0;
        end else if (ser_rise) begin
            shift_r <= {shift_r[SHIFT_W-2:0], i_ser_data};
        end
    end

    // Configuration latches; parallel side checked first
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            cfg_m_r <= '0;
            cfg_n_r <= '0;
            cfg_t_r <= TEST_SHIFT;
        end else if (!i_par_load_n) begin
            cfg_m_r <= i_par_m;
            cfg_n_r <= i_par_n;
            cfg_t_r <= TEST_SHIFT;
        end else if (i_ser_load || ser_load_fall) begin
            cfg_m_r <= shift_r[SH_M_LSB +: M_W];
            cfg_n_r <= shift_r[SH_N_LSB +: N_W];
            cfg_t_r <= shift_r[SH_T_LSB +: T_W];
        end
        // Otherwise hold: the rising parallel edge left the last pins in place
    end

    // Reference pre-divide by eight, square wave
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            ref_cnt_r <= 3'h0;
            fref_r    <= 1'b0;
        end else if (i_xtal_tick) begin
            ref_cnt_r <= ref_cnt_r + 3'h1;
            if (ref_cnt_r == REF_HALF || ref_cnt_r == REF_LAST) begin
                fref_r <= ~fref_r;
            end
        end
    end
    assign fref_evt = i_xtal_tick & (ref_cnt_r == REF_LAST);

    // Bypass takes the serial clock into both dividers
    assign div_tick = bypass ? ser_rise : i_vco_tick;

    // Loop divider: one feedback event per M oscillator ticks
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            loop_cnt_r <= '0;
            mcnt_out_r <= 1'b0;
        end else if (div_tick) begin
            if (loop_cnt_r + 9'h001 >= cfg_m_r) begin
                loop_cnt_r <= '0;
                mcnt_out_r <= 1'b1;
            end else begin
                loop_cnt_r <= loop_cnt_r + 9'h001;
                mcnt_out_r <= 1'b0;
            end
        end
    end
    assign fb_evt = div_tick & (loop_cnt_r + 9'h001 >= cfg_m_r);

    // Phase-frequency compare: both set means aligned, clear both
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            up_r   <= 1'b0;
            down_r <= 1'b0;
        end else if ((up_r | fref_evt) & (down_r | fb_evt)) begin
            up_r   <= 1'b0;
            down_r <= 1'b0;
        end else begin
            up_r   <= up_r | fref_evt;
            down_r <= down_r | fb_evt;
        end
    end
    assign o_pump_up   = up_r;
    assign o_pump_down = down_r;

    // Output divider with synchronous enable
    out_divider u_out_div (
        .i_clock  (i_clock),
        .i_srst   (i_srst),
        .i_tick   (div_tick),
        .i_ratio  (cfg_n_r),
        .i_enable (i_out_en & ctrl_oe_r),
        .o_clock  (synth_clock_out_gated),
        .o_level  (synth_clock_out_level)
    );

    // Output divided once more by four for the test pin
    assign synth_clock_out_rise = synth_clock_out_level & ~synth_clock_out_prev_r;
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            synth_clock_out_prev_r <= 1'b0;
            f4_cnt_r    <= 2'h0;
        end else begin
            synth_clock_out_prev_r <= synth_clock_out_level;
            if (synth_clock_out_rise) begin
                f4_cnt_r <= f4_cnt_r + 2'h1;
            end
        end
    end

    // Test node select; output registered so the pin never glitches
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            test_r <= 1'b0;
        end else begin
            case (cfg_t_r)
                TEST_SHIFT:  test_r <= shift_r[SHIFT_W-1];
                TEST_HIGH:   test_r <= 1'b1;
                TEST_FREF:   test_r <= fref_r;
                TEST_MCNT:   test_r <= mcnt_out_r;
                TEST_SYNTH_CLOCK_OUT:   test_r <= synth_clock_out_level;
                TEST_LOW:    test_r <= 1'b0;
                TEST_BYPASS: test_r <= mcnt_out_r;
                TEST_FOUT4:  test_r <= f4_cnt_r[1];
                default:     test_r <= 1'b0;
            endcase
        end
    end
    assign o_test_out        = test_r;
    assign o_synth_clock_out = synth_clock_out_gated;

    // AXI write: address and data taken in either order
    assign o_awready = (wr_state_r == WR_COLLECT) & ~aw_have_r;
    assign o_wready  = (wr_state_r == WR_COLLECT) & ~w_have_r;

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            wr_state_r <= WR_COLLECT;
            aw_have_r  <= 1'b0;
            w_have_r   <= 1'b0;
            waddr_r    <= 8'h00;
            wdata_r    <= 32'h0000_0000;
            wstrb0_r   <= 1'b0;
            o_bvalid   <= 1'b0;
            o_bresp    <= RESP_OKAY;
        end else begin
            case (wr_state_r)
                WR_COLLECT: begin
                    if (i_awvalid && o_awready) begin
                        aw_have_r <= 1'b1;
                        waddr_r   <= i_awaddr;
                    end
                    if (i_wvalid && o_wready) begin
                        w_have_r <= 1'b1;
                        wdata_r  <= i_wdata;
                        wstrb0_r <= i_wstrb[0];
                    end
                    if (aw_have_r && w_have_r) begin
                        wr_state_r <= WR_RESP;
                        o_bvalid   <= 1'b1;
                        o_bresp    <= (waddr_r == ADDR_CTRL) ? RESP_OKAY : RESP_SLVERR;
                    end
                end
                WR_RESP: begin
                    if (i_bready) begin
                        wr_state_r <= WR_COLLECT;
                        o_bvalid   <= 1'b0;
                        aw_have_r  <= 1'b0;
                        w_have_r   <= 1'b0;
                    end
                end
                default: wr_state_r <= WR_COLLECT;
            endcase
        end
    end

    // Control register: software can hold the output off
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            ctrl_oe_r <= CTRL_OE_RESET;
        end else if (wr_state_r == WR_COLLECT && aw_have_r && w_have_r
                     && waddr_r == ADDR_CTRL && wstrb0_r) begin
            ctrl_oe_r <= wdata_r[CTRL_OE_BIT];
        end
    end

    // AXI read: one cycle to answer, held until taken
    assign o_arready = ~o_rvalid;
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            o_rvalid <= 1'b0;
            o_rdata  <= 32'h0000_0000;
            o_rresp  <= RESP_OKAY;
        end else if (o_rvalid) begin
            if (i_rready) begin
                o_rvalid <= 1'b0;
            end
        end else if (i_arvalid) begin
            o_rvalid <= 1'b1;
            o_rresp  <= RESP_OKAY;
            case (i_araddr)
                ADDR_CTRL:   o_rdata <= 32'(ctrl_oe_r);
                ADDR_CONFIG: o_rdata <= 32'({cfg_t_r, cfg_n_r, cfg_m_r});
                ADDR_SHIFT:  o_rdata <= 32'(shift_r);
                ADDR_PUMP:   o_rdata <= 32'({down_r, up_r});
                default: begin
                    o_rdata <= 32'h0000_0000;
                    o_rresp <= RESP_SLVERR;
                end
            endcase
        end
    end

    // Checks on the configuration path
    sequence par_open_s;
        !i_par_load_n;
    endsequence
    sequence ser_commit_s;
        i_par_load_n && ser_load_fall;
    endsequence

    par_transp_a: assert property (@(posedge i_clock) disable iff (i_srst)
        par_open_s |=> (cfg_m_r == $past(i_par_m) && cfg_n_r == $past(i_par_n)))
        else $error("parallel latch not transparent");
    test_force_a: assert property (@(posedge i_clock) disable iff (i_srst)
        par_open_s |=> cfg_t_r == TEST_SHIFT)
        else $error("test select not forced to zero");
    par_wins_a: assert property (@(posedge i_clock) disable iff (i_srst)
        (par_open_s and i_ser_load) |=> cfg_m_r == $past(i_par_m))
        else $error("serial load overrode parallel");
    ser_capture_a: assert property (@(posedge i_clock) disable iff (i_srst)
        ser_commit_s |=> {cfg_t_r, cfg_n_r, cfg_m_r} == $past(shift_r))
        else $error("serial strobe did not capture");
    cfg_hold_a: assert property (@(posedge i_clock) disable iff (i_srst)
        (i_par_load_n && !i_ser_load && !ser_load_fall) |=> $stable(cfg_m_r))
        else $error("configuration changed while latched");
    shift_in_a: assert property (@(posedge i_clock) disable iff (i_srst)
        ser_rise |=> shift_r[0] == $past(i_ser_data) && shift_r[1] == $past(shift_r[0]))
        else $error("shift register did not shift");
    ref_rate_a: assert property (@(posedge i_clock) disable iff (i_srst)
        fref_evt |=> fref_r == 1'b0 && ref_cnt_r == 3'h0)
        else $error("reference divide misaligned");
    test_high_a: assert property (@(posedge i_clock) disable iff (i_srst)
        (cfg_t_r == TEST_HIGH) |=> test_r)
        else $error("test pin not high");
    bypass_a: assert property (@(posedge i_clock) disable iff (i_srst)
        (bypass && i_vco_tick && !ser_rise && loop_cnt_r + 9'h001 < cfg_m_r)
        |=> $stable(loop_cnt_r))
        else $error("oscillator ticked dividers in bypass");
endmodule // pll_divider_config_loader
`default_nettype wire

// ==== verif/cfg_host.sv ====
// Host model driving the synthesizer configuration pins.
// Assumes its tasks are called from the bench, one at a time.
`timescale 1ns/1ps
`default_nettype none
module cfg_host
    import pll_cfg_pkg::*;
(
    input  wire logic      i_clock,   // System clock
    output logic           o_xtal,    // Reference event
    output logic           o_vco,     // Oscillator event
    output logic [M_W-1:0] o_m,       // Parallel loop divider
    output logic [N_W-1:0] o_n,       // Parallel output code
    output logic           o_pload_n, // Parallel strobe
    output logic           o_sclk,    // Serial clock
    output logic           o_sdata,   // Serial data
    output logic           o_sload    // Serial strobe
);
    logic tick_on = 1'b1;
    // Oscillator events every cycle; they are never stopped, not even in bypass
    assign o_xtal = tick_on;
    assign o_vco  = tick_on;
    // Pins idle low like their pull-downs; parallel strobe low in reset
    initial begin
        o_m       = 9'h000;
        o_n       = 2'h0;
        o_pload_n = 1'b0;
        o_sclk    = 1'b0;
        o_sdata   = 1'b0;
        o_sload   = 1'b0;
    end
    // Parallel pins and strobe level
    task automatic par(input logic [8:0] m, input logic [1:0] n, input logic ld_n);
        @(posedge i_clock);
        o_m       <= m;
        o_n       <= n;
        o_pload_n <= ld_n;
    endtask
    // One serial clock period, high then low for a cycle each
    task automatic pulse;
        @(posedge i_clock);
        o_sclk <= 1'b1;
        @(posedge i_clock);
        o_sclk <= 1'b0;
    endtask
    // Stream of fourteen bits, first bit is the top one
    task automatic send(input logic [SHIFT_W-1:0] w);
        for (int i = SHIFT_W - 1; i >= 0; i--) begin
            @(posedge i_clock);
            o_sdata <= w[i];
            pulse();
        end
        @(posedge i_clock);
        o_sdata <= 1'b0;
    endtask
    // Strobe pulse; no shifting meanwhile keeps the data stable
    task automatic strobe;
        @(posedge i_clock);
        o_sload <= 1'b1;
        repeat (2) @(posedge i_clock);
        o_sload <= 1'b0;
        repeat (3) @(posedge i_clock);
    endtask
endmodule // cfg_host
`default_nettype wire

// ==== verif/testbench.sv ====
// Self-checking bench for the synthesizer configuration loader.
// Assumes the host model drives every configuration pin.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import pll_cfg_pkg::*;
    logic        clock   = 1'b0;
    logic        srst    = 1'b1;
    logic        out_en  = 1'b1;
    logic [7:0]  awaddr  = 8'h00;
    logic        awvalid = 1'b0;
    logic [31:0] wdata   = 32'h0000_0000;
    logic [3:0]  wstrb   = 4'h0;
    logic        wvalid  = 1'b0;
    logic        bready  = 1'b0;
    logic [7:0]  araddr  = 8'h00;
    logic        arvalid = 1'b0;
    logic        rready  = 1'b0;
    logic        xtal, vco, pload_n, sclk, sdata, sload;
    logic [8:0]  m;
    logic [1:0]  n;
    logic        awready, wready, bvalid, arready, rvalid, synth, test, p_up, p_dn;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    int          err_total = 0;
    int          checks    = 0;
    // 100 MHz clock
    always #5 clock = ~clock;
    cfg_host host_u (.i_clock(clock), .o_xtal(xtal), .o_vco(vco), .o_m(m), .o_n(n),
        .o_pload_n(pload_n), .o_sclk(sclk), .o_sdata(sdata), .o_sload(sload));
    pll_divider_config_loader dut_u (.i_clock(clock), .i_srst(srst), .i_xtal_tick(xtal),
        .i_vco_tick(vco), .i_par_m(m), .i_par_n(n), .i_par_load_n(pload_n),
        .i_ser_clock(sclk), .i_ser_data(sdata), .i_ser_load(sload), .i_out_en(out_en),
        .o_synth_clock_out(synth), .o_test_out(test), .o_pump_up(p_up),
        .o_pump_down(p_dn), .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
        .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
        .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr),
        .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp),
        .o_rvalid(rvalid), .i_rready(rready));
    // Verdict and end of run
    task automatic finish_test;
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic hang;
        err_total++;
        $display("BAD %0t wait ran out", $time);
        finish_test();
    endtask
    task automatic chk(input logic ok, input string msg);
        checks++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask
    // Expected config word: select, output code, loop divider
    function automatic logic [31:0] cw(input logic [2:0] t, input logic [1:0] c,
                                       input logic [8:0] v);
        return {18'h0_0000, t, c, v};
    endfunction
    // Register write; address and data offered together
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_ok;
        logic w_ok;
        int   k;
        aw_ok = 1'b0;
        w_ok  = 1'b0;
        k     = 0;
        @(posedge clock);
        awaddr  <= a;
        awvalid <= 1'b1;
        wdata   <= d;
        wstrb   <= 4'hF;
        wvalid  <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge clock);
            if (!aw_ok && awready === 1'b1) begin
                awvalid <= 1'b0;
                aw_ok = 1'b1;
            end
            if (!w_ok && wready === 1'b1) begin
                wvalid <= 1'b0;
                w_ok = 1'b1;
            end
            k++;
            if (k > 50) hang();
        end
        bready <= 1'b1;
        do begin
            @(posedge clock);
            k++;
            if (k > 100) hang();
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk(bresp === er, "write response");
    endtask
    // Register read compared with the expected word
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int k;
        k = 0;
        @(posedge clock);
        araddr  <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge clock);
            k++;
            if (k > 50) hang();
        end while (arready !== 1'b1);
        arvalid <= 1'b0;
        rready  <= 1'b1;
        do begin
            @(posedge clock);
            k++;
            if (k > 100) hang();
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk(rdata === ed && rresp === er, "read data or response");
    endtask
    function automatic logic pick(input logic sel);
        return sel ? test : synth;
    endfunction
    // One high and one low run; low runs are cut at 40 cycles
    task automatic runs(input logic sel, input int hi_e, input int lo_e, input logic drop);
        int hi;
        int lo;
        int k;
        hi = 0;
        lo = 0;
        k  = 0;
        while (pick(sel) !== 1'b0 && k < 300) begin
            @(posedge clock);
            k++;
        end
        while (pick(sel) !== 1'b1 && k < 300) begin
            @(posedge clock);
            k++;
        end
        if (k >= 300) hang();
        if (drop) out_en <= 1'b0;
        while (pick(sel) === 1'b1 && hi < 300) begin
            @(posedge clock);
            hi++;
        end
        while (pick(sel) === 1'b0 && lo < 40) begin
            @(posedge clock);
            lo++;
        end
        chk(hi == hi_e && lo == lo_e, "run length");
    endtask
    // Main sequence
    initial begin
        logic [31:0] w;
        logic [31:0] old;
        logic        s;
        int          dn;
        repeat (12) @(posedge clock);
        srst <= 1'b0;
        rd(ADDR_CTRL, 32'h0000_0001, RESP_OKAY);
        rd(ADDR_CONFIG, 32'h0000_0000, RESP_OKAY);
        // Loop divider of zero runs ahead of the reference: pump down, never up
        dn = 0;
        repeat (16) begin
            @(posedge clock);
            if (p_dn === 1'b1) dn++;
            if (p_up !== 1'b0) dn = 99;
        end
        chk(dn == 14, "pump direction");
        rd(8'h10, 32'h0000_0000, RESP_SLVERR);
        axw(8'h10, 32'h0000_0000, RESP_SLVERR);
        host_u.par(9'h106, 2'h1, 1'b0);
        rd(ADDR_CONFIG, cw(3'h0, 2'h1, 9'h106), RESP_OKAY);
        host_u.par(9'h106, 2'h1, 1'b1);
        host_u.par(9'h0AA, 2'h2, 1'b1);
        rd(ADDR_CONFIG, cw(3'h0, 2'h1, 9'h106), RESP_OKAY);
        old = cw(3'h0, 2'h1, 9'h106);
        // Static test pin codes through the serial port
        for (int t = 1; t < 6; t += 4) begin
            w = cw(3'(t), 2'h2, 9'h1C5);
            host_u.send(w[13:0]);
            rd(ADDR_SHIFT, w, RESP_OKAY);
            rd(ADDR_CONFIG, old, RESP_OKAY);
            host_u.strobe();
            rd(ADDR_CONFIG, w, RESP_OKAY);
            chk(test === (t == 1), "test pin level");
            old = w;
        end
        w = cw(TEST_FREF, 2'h0, 9'h010);
        host_u.send(w[13:0]);
        host_u.strobe();
        runs(1'b1, 4, 4, 1'b0);
        host_u.par(9'h055, 2'h3, 1'b0);
        w = cw(3'h5, 2'h0, 9'h1FF);
        host_u.send(w[13:0]);
        host_u.strobe();
        rd(ADDR_CONFIG, cw(3'h0, 2'h3, 9'h055), RESP_OKAY);
        chk(test === w[13], "shift out on test pin");
        for (int c = 0; c < 4; c++) begin
            host_u.par(9'h010, 2'(c), 1'b0);
            repeat (40) @(posedge clock);
            runs(1'b0, 1 << c, 1 << c, 1'b0);
        end
        runs(1'b0, 8, 40, 1'b1);
        out_en <= 1'b1;
        axw(ADDR_CTRL, 32'h0000_0000, RESP_OKAY);
        rd(ADDR_CTRL, 32'h0000_0000, RESP_OKAY);
        repeat (30) @(posedge clock);
        chk(synth === 1'b0, "software enable off");
        axw(ADDR_CTRL, 32'h0000_0001, RESP_OKAY);
        // Bypass: serial clock alone steps the output divider
        // Oscillator keeps ticking: an even toggle count would expose it
        host_u.par(9'h002, 2'h0, 1'b1);
        w = cw(TEST_BYPASS, 2'h0, 9'h002);
        host_u.send(w[13:0]);
        host_u.strobe();
        for (int k = 0; k < 2; k++) begin
            s = synth;
            host_u.pulse();
            repeat (4) @(posedge clock);
            chk(synth === ~s, "bypass toggle");
        end
        finish_test();
    end
endmodule // testbench
`default_nettype wire
